// ---- pkg/pic_pkg.sv ----
// Purpose: Shared constants, types and count arithmetic for the interval counter.
// Assumes: One system clock; host and counter pins are synchronous to it.
// Notes:   Decimal arithmetic works digit by digit with borrow.

package pic_pkg;

  // ***************************************************************
  // Port addresses and control word fields
  // ***************************************************************
  localparam logic [1:0] PIC_ADDR_CTRL  = 2'h3;  // Control word port (offset 0x3)
  localparam logic [1:0] PIC_SEL_BAD    = 2'h3;  // Counter select code that is illegal
  localparam logic [1:0] PIC_ACC_LATCH  = 2'h0;  // Byte access code: latch command
  localparam logic [1:0] PIC_ACC_LSB    = 2'h1;  // Low byte only
  localparam logic [1:0] PIC_ACC_MSB    = 2'h2;  // High byte only
  localparam logic [1:0] PIC_ACC_BOTH   = 2'h3;  // Low byte then high byte
  localparam int         PIC_NUM_CNT    = 3;     // Counters in the block

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [15:0] PIC_COUNT_RST = 16'h0000;
  localparam logic [7:0]  PIC_DATA_RST  = 8'h00;
  localparam logic [1:0]  PIC_ACC_RST   = 2'h1;
  localparam logic        PIC_OUT_RST   = 1'b0;

  // Decoded counting modes, one-hot
  typedef enum logic [5:0] {
    PIC_M0 = 6'b000001,
    PIC_M1 = 6'b000010,
    PIC_M2 = 6'b000100,
    PIC_M3 = 6'b001000,
    PIC_M4 = 6'b010000,
    PIC_M5 = 6'b100000
  } pic_mode_t;

  // Control word layout
  typedef struct packed {
    logic [1:0] counter_select;  // counter_select_hi, counter_select_lo
    logic [1:0] byte_access;     // byte_access_hi, byte_access_lo
    logic [2:0] mode_sel;        // mode_sel_2 .. mode_sel_0
    logic       bcd;             // Decimal arithmetic
  } pic_ctl_t;

  // Host port pins
  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic       port_select_1;
    logic       port_select_0;
    logic [7:0] data;
  } pic_bus_t;

  // Mode field decode; top bit is a don't care for modes 2 and 3
  function automatic pic_mode_t pic_decode(input logic [2:0] m);
    pic_mode_t r;
    r = PIC_M0;
    case (m)
      3'h0:       r = PIC_M0;
      3'h1:       r = PIC_M1;
      3'h2, 3'h6: r = PIC_M2;
      3'h3, 3'h7: r = PIC_M3;
      3'h4:       r = PIC_M4;
      3'h5:       r = PIC_M5;
      default:    r = PIC_M0;
    endcase
    return r;
  endfunction

  // Subtract n (0..3) in binary or four-digit decimal, wrapping below zero
  function automatic logic [15:0] pic_sub(input logic [15:0] v, input logic [1:0] n,
                                          input logic bcd);
    logic [15:0] r;
    logic        borrow;
    r = v;
    for (int k = 0; k < 3; k++) begin
      if (k < int'(n)) begin
        if (!bcd) begin
          r = r - 16'h0001;
        end else begin
          borrow = 1'b1;
          for (int d = 0; d < 4; d++) begin
            if (borrow) begin
              if (r[4*d +: 4] == 4'h0) begin
                r[4*d +: 4] = 4'h9;
              end else begin
                r[4*d +: 4] = r[4*d +: 4] - 4'h1;
                borrow = 1'b0;
              end
            end
          end
        end
      end
    end
    return r;
  endfunction

endpackage

// ---- hdl/pic_timer.sv ----
// Purpose: Three independent 16-bit down counters with a write-only control word.
// Assumes: Host strobes, counter clocks and gates are synchronous to clk.
// Notes:   Counter clock edges are found by sampling; counting acts on falling edges.
//
// Notes on behaviour
// - Control word taken at port 11; bits 7:6 pick counter, 11 is illegal.
// - Bits 5:4 choose latch, low only, high only, or low then high.
// - Byte access 00 is a latch command and leaves configuration alone.
// - Bit 0 selects sixteen-bit binary or four-digit decimal down count.
// - Written count enters after all bytes, then a counter clock rise and fall.
// - Mode 0 output low from mode set, high at terminal count, keeps counting.
// - Mode 0 first byte of rewrite halts counting, second byte starts new count.
// - Mode 1 output low after gate rise, high at terminal count, retriggerable.
// - Mode 1 new count waits for next trigger; reads never disturb the pulse.
// - Mode 2 divides by N, one low clock per period, reload next period.
// - Mode 2 gate low forces high, gate rise restarts; high until loaded.
// - Mode 3 counts down by two, toggles output and reloads at terminal count.
// - Mode 3 odd count steps 1 then 3 at phase starts; halves (N+1)/2, (N-1)/2.
// - Mode 4 output high at mode set; one low clock at terminal count.
// - Mode 4 rewrite taken next counter clock; gate low holds counting.
// - Mode 5 counts after gate rise, one low clock at end, rise restarts.
// - Gate level enables modes 0,2,3,4; only rising edge matters in 1 and 5.
// - Latch command copies present count for later reads without disturbing it.
// - Count of zero yields 65536 binary or 10000 decimal clocks.
// - Two-byte reads return low byte first, then high byte.

module pic_timer
  import pic_pkg::*;
(
  // System
  input  wire logic                   clk,
  input  wire logic                   rstn,
  // Host port
  input  wire pic_pkg::pic_bus_t      bus,
  output logic      [7:0]             data_out,
  output logic                        data_oe,
  // Counter pins
  input  wire logic [2:0]             cnt_clk,
  input  wire logic [2:0]             gate,
  output logic      [2:0]             cnt_out
);
  import pic_pkg::*;

  // ***************************************************************
  // Host port decode
  // ***************************************************************
  logic       wr_prev;
  logic       rd_prev;
  logic [1:0] addr;
  logic       wr_take;
  logic       rd_take;
  pic_ctl_t   ctl;
  logic       ctl_write;
  logic [7:0] rd_byte [PIC_NUM_CNT];

  assign addr      = {bus.port_select_1, bus.port_select_0};
  assign ctl       = pic_ctl_t'(bus.data);
  // A write or read is taken on the cycle its strobe first goes low
  assign wr_take   = !bus.cs_n && !bus.wr_n && wr_prev;
  assign rd_take   = !bus.cs_n && !bus.rd_n && rd_prev && (addr != PIC_ADDR_CTRL);
  assign ctl_write = wr_take && (addr == PIC_ADDR_CTRL) &&
                     (ctl.counter_select != PIC_SEL_BAD);

  // Strobe history for edge detection
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_prev <= 1'b1;
      rd_prev <= 1'b1;
    end else begin
      wr_prev <= bus.wr_n | bus.cs_n;
      rd_prev <= bus.rd_n | bus.cs_n;
    end
  end

  // Read data register, loaded from the addressed counter
  always_ff @(posedge clk) begin
    if (!rstn) begin
      data_out <= PIC_DATA_RST;
    end else if (rd_take) begin
      data_out <= rd_byte[addr];
    end
  end

  // Bus driven only while a counter is read
  assign data_oe = !bus.cs_n && !bus.rd_n && (addr != PIC_ADDR_CTRL);

  // ***************************************************************
  // Counters
  // ***************************************************************
  for (genvar i = 0; i < PIC_NUM_CNT; i++) begin : g_cnt
    pic_mode_t   mode;
    logic [1:0]  access;
    logic        bcd;
    logic [15:0] init;        // Count register
    logic [15:0] count;       // Counting element
    logic        wr_hi;       // Next written byte is the high one
    logic        rd_hi;       // Next read byte is the high one
    logic        pend;        // Count written, awaiting a clock rise
    logic        pend_rise;   // Rise seen, load on the next fall
    logic        halt;        // Mode 0 rewrite in progress
    logic [15:0] latch;
    logic        latched;
    logic        armed;       // Counting element holds a live count
    logic        first;       // First clock of a mode 3 phase
    logic        trig;        // Gate rise awaiting a counter clock
    logic        out;
    logic        clk_prev;
    logic        gate_prev;
    logic        cfall;
    logic        crise;
    logic        gate_rise;
    logic        sel;
    logic        set_mode;
    logic        latch_cmd;
    logic        cnt_write;
    logic        cnt_read;
    logic        load;
    logic        gate_en;
    logic [15:0] rd_src;
    logic [1:0]  step;
    logic [15:0] next_count;

    assign sel       = ctl.counter_select == 2'(i);
    assign set_mode  = ctl_write && sel && (ctl.byte_access != PIC_ACC_LATCH);
    assign latch_cmd = ctl_write && sel && (ctl.byte_access == PIC_ACC_LATCH);
    assign cnt_write = wr_take && (addr == 2'(i));
    assign cnt_read  = rd_take && (addr == 2'(i));
    assign cfall     = clk_prev && !cnt_clk[i];
    assign crise     = !clk_prev && cnt_clk[i];
    assign gate_rise = gate[i] && !gate_prev;
    assign load      = pend_rise && cfall;
    // Gate level enables counting only in modes 0, 2, 3 and 4
    assign gate_en   = (mode == PIC_M1 || mode == PIC_M5) ? 1'b1 : gate[i];
    assign rd_src    = latched ? latch : count;
    assign cnt_out[i] = out;

    // Mode 3 step: 1 at start of odd high phase, 3 at start of odd low phase
    always_comb begin
      step = 2'h2;
      if (first && init[0]) begin
        step = out ? 2'h1 : 2'h3;
      end
      next_count = pic_sub(count, (mode == PIC_M3) ? step : 2'h1, bcd);
    end

    // Byte presented to a read: latched value wins over the live count
    always_comb begin
      case (access)
        PIC_ACC_MSB:  rd_byte[i] = rd_src[15:8];
        PIC_ACC_BOTH: rd_byte[i] = rd_hi ? rd_src[15:8] : rd_src[7:0];
        default:      rd_byte[i] = rd_src[7:0];
      endcase
    end

    // Pin history
    always_ff @(posedge clk) begin
      if (!rstn) begin
        clk_prev  <= 1'b0;
        gate_prev <= 1'b1;  // Idle high gate gives no false rise after reset
      end else begin
        clk_prev  <= cnt_clk[i];
        gate_prev <= gate[i];
      end
    end

    // Configuration, count register writes and load sequencing
    always_ff @(posedge clk) begin
      if (!rstn) begin
        mode      <= PIC_M0;
        access    <= PIC_ACC_RST;
        bcd       <= 1'b0;
        init      <= PIC_COUNT_RST;
        wr_hi     <= 1'b0;
        pend      <= 1'b0;
        pend_rise <= 1'b0;
        halt      <= 1'b0;
      end else if (set_mode) begin
        mode      <= pic_decode(ctl.mode_sel);
        access    <= ctl.byte_access;
        bcd       <= ctl.bcd;
        wr_hi     <= 1'b0;
        pend      <= 1'b0;
        pend_rise <= 1'b0;
        halt      <= 1'b0;
      end else begin
        if (crise && pend) begin
          pend      <= 1'b0;
          pend_rise <= 1'b1;
        end
        if (load) begin
          pend_rise <= 1'b0;
          halt      <= 1'b0;
        end
        if (cnt_write) begin
          case (access)
            PIC_ACC_MSB: begin
              init <= {bus.data, 8'h00};
              pend <= 1'b1;
            end
            PIC_ACC_BOTH: begin
              if (!wr_hi) begin
                init[7:0] <= bus.data;
                wr_hi     <= 1'b1;
                pend      <= 1'b0;
                pend_rise <= 1'b0;
                halt      <= (mode == PIC_M0);
              end else begin
                init[15:8] <= bus.data;
                wr_hi      <= 1'b0;
                pend       <= 1'b1;
              end
            end
            default: begin
              init <= {8'h00, bus.data};
              pend <= 1'b1;
            end
          endcase
        end
      end
    end

    // Read byte order and count latch
    always_ff @(posedge clk) begin
      if (!rstn || set_mode) begin
        rd_hi   <= 1'b0;
        latch   <= PIC_COUNT_RST;
        latched <= 1'b0;
      end else begin
        if (latch_cmd && !latched) begin
          latch   <= count;
          latched <= 1'b1;
        end
        if (cnt_read) begin
          if (access == PIC_ACC_BOTH && !rd_hi) begin
            rd_hi <= 1'b1;
          end else begin
            rd_hi   <= 1'b0;
            latched <= 1'b0;
          end
        end
      end
    end

    // Counting element and output
    always_ff @(posedge clk) begin
      if (!rstn) begin
        count <= PIC_COUNT_RST;
        armed <= 1'b0;
        first <= 1'b0;
        trig  <= 1'b0;
        out   <= PIC_OUT_RST;
      end else if (set_mode) begin
        armed <= 1'b0;
        trig  <= 1'b0;
        out   <= (pic_decode(ctl.mode_sel) != PIC_M0);
      end else begin
        // Gate low holds the output high in the rate modes
        if (!gate[i] && (mode == PIC_M2 || mode == PIC_M3)) begin
          out <= 1'b1;
        end
        if (cfall) begin
          trig <= 1'b0;
          // Strobe modes hold low for exactly one counter clock
          if (!out && (mode == PIC_M4 || mode == PIC_M5)) begin
            out <= 1'b1;
          end
          if (load && (mode == PIC_M0 || mode == PIC_M4 || !armed) &&
              mode != PIC_M1 && mode != PIC_M5) begin
            count <= init;
            armed <= 1'b1;
            first <= 1'b1;
            if (mode == PIC_M0) begin
              out <= 1'b0;
            end
          end else if (trig && (mode == PIC_M1 || mode == PIC_M5 ||
                       ((mode == PIC_M2 || mode == PIC_M3) && armed))) begin
            count <= init;
            armed <= 1'b1;
            first <= 1'b1;
            out   <= (mode != PIC_M1);
          end else if (armed && gate_en && !halt &&
                       !(mode == PIC_M0 && (pend || pend_rise))) begin
            case (mode)
              PIC_M0: begin
                count <= next_count;
                if (count == 16'h0001) begin
                  out <= 1'b1;
                end
              end
              PIC_M1: begin
                count <= next_count;
                if (count == 16'h0001) begin
                  out   <= 1'b1;
                  armed <= 1'b0;
                end
              end
              PIC_M2: begin
                if (count == 16'h0001) begin
                  count <= init;
                  out   <= 1'b1;
                end else begin
                  count <= next_count;
                  out   <= (count != 16'h0002);
                end
              end
              PIC_M3: begin
                if (next_count == 16'h0000) begin
                  count <= init;
                  out   <= !out;
                  first <= 1'b1;
                end else begin
                  count <= next_count;
                  first <= 1'b0;
                end
              end
              PIC_M4, PIC_M5: begin
                count <= next_count;
                if (count == 16'h0001) begin
                  out   <= 1'b0;
                  armed <= 1'b0;
                end
              end
              default: begin
                count <= count;
              end
            endcase
          end
        end
        // A gate rise arriving with a counter clock is kept, not lost
        if (gate_rise && gate_en) begin
          trig <= 1'b1;
        end
      end
    end
  end

endmodule

// ---- tb/pic_host_model.sv ----
// Purpose: Host CPU side of the counter's I/O port.
// Assumes: Strobes change just after falling clk edges.
// Notes:   Released data lines show the inverse of the last byte.
module pic_host_model
  import pic_pkg::*;
(
  // System
  input  wire logic              clk,
  // Host port
  output pic_pkg::pic_bus_t      bus,
  input  wire logic [7:0]        data_out,
  input  wire logic              data_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  // ********************************
  // Bus cycles
  // ********************************

  // Port idle, nothing selected
  initial begin
    bus = '1;
  end

  // Write one byte, then one idle cycle before the next access
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(negedge clk);
    bus = {3'b010, a, d};
    @(negedge clk);
    bus = {3'b111, a, ~d};
  endtask

  // Read one byte; strobe held two cycles, data taken before release
  task automatic rd(input logic [1:0] a, output logic [7:0] d, output logic oe);
    @(negedge clk);
    bus = {3'b001, a, ~bus.data};
    @(posedge clk);
    @(posedge clk);
    #1;
    d = data_out;
    oe = data_oe;
    @(negedge clk);
    bus = {3'b111, a, ~bus.data};
  endtask
endmodule

// ---- tb/pic_timer_assertions.sv ----
// Purpose: Port-level checks of the interval counter.
// Assumes: Sees only the ports of pic_timer.
// Notes:   Mode tracking covers counter 0 and counter 2.
module pic_timer_assertions
  import pic_pkg::*;
(
  // System
  input  wire logic              clk,
  input  wire logic              rstn,
  // Host port
  input  wire pic_pkg::pic_bus_t bus,
  input  wire logic [7:0]        data_out,
  input  wire logic              data_oe,
  // Counter pins
  input  wire logic [2:0]        cnt_clk,
  input  wire logic [2:0]        gate,
  input  wire logic [2:0]        cnt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       idle_wr, idle_rd, wt, rt, cw, mode0_c0, mode2_c2, dirty0;
  logic [1:0] addr;
  logic [2:0] clk_d, gate_d;
  logic [5:0] evt;
  pic_ctl_t   ctl;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // ********************************
  // Helper logic
  // ********************************

  // Access takes and control word view
  assign addr = {bus.port_select_1, bus.port_select_0};
  assign wt   = !bus.cs_n && !bus.wr_n && idle_wr;
  assign rt   = !bus.cs_n && !bus.rd_n && idle_rd;
  assign cw   = wt && addr == 2'h3;
  assign ctl  = pic_ctl_t'(bus.data);

  // Strobe history and recent pin or write events
  always_ff @(posedge clk) begin
    idle_wr <= !rstn || bus.wr_n || bus.cs_n;
    idle_rd <= !rstn || bus.rd_n || bus.cs_n;
    clk_d   <= cnt_clk;
    gate_d  <= gate;
    evt     <= rstn ? {evt[4:0], (|(clk_d & ~cnt_clk)) | (|(gate_d ^ gate)) | wt} : 6'h00;
  end

  // Mode of counters 0 and 2, and pending rewrite of counter 0
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode0_c0 <= 1'b1;
      mode2_c2 <= 1'b0;
      dirty0   <= 1'b1;
    end else begin
      if (cw && ctl.byte_access != PIC_ACC_LATCH && ctl.counter_select == 2'h0) begin
        mode0_c0 <= ctl.mode_sel == 3'h0;
      end
      if (cw && ctl.byte_access != PIC_ACC_LATCH && ctl.counter_select == 2'h2) begin
        mode2_c2 <= ctl.mode_sel[1:0] == 2'h2;
      end
      if ((wt && addr == 2'h0) || (cw && ctl.counter_select == 2'h0)) begin
        dirty0 <= 1'b1;
      end else if ($rose(cnt_out[0])) begin
        dirty0 <= 1'b0;
      end
    end
  end

  property p_oe;
    data_oe == (!bus.cs_n && !bus.rd_n && addr != 2'h3);
  endproperty
  a_oe: assert property (p_oe) else $error("data_oe wrong");

  property p_rd_hold;
    !$past(rt) |-> $stable(data_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("data_out moved without read");

  property p_quiet;
    $changed(cnt_out) |-> |evt;
  endproperty
  a_quiet: assert property (p_quiet) else $error("cnt_out moved without cause");

  property p_m0_set;
    cw && ctl.counter_select == 2'h0 && ctl.byte_access != 2'h0 && ctl.mode_sel == 3'h0
      |-> ##[1:3] !cnt_out[0];
  endproperty
  a_m0_set: assert property (p_m0_set) else $error("mode 0 set not low");

  property p_m4_set;
    cw && ctl.counter_select == 2'h1 && ctl.byte_access != 2'h0 && ctl.mode_sel == 3'h4
      |-> ##3 cnt_out[1];
  endproperty
  a_m4_set: assert property (p_m4_set) else $error("mode 4 set not high");

  property p_m2_set;
    cw && ctl.counter_select == 2'h2 && ctl.byte_access != 2'h0 && ctl.mode_sel[1:0] == 2'h2
      |-> ##3 cnt_out[2];
  endproperty
  a_m2_set: assert property (p_m2_set) else $error("mode 2 set not high");

  property p_m2_gate;
    mode2_c2 && !gate[2] |-> ##[1:2] cnt_out[2];
  endproperty
  a_m2_gate: assert property (p_m2_gate) else $error("gate low not forcing high");

  property p_m0_hold;
    mode0_c0 && cnt_out[0] && !dirty0 |=> cnt_out[0];
  endproperty
  a_m0_hold: assert property (p_m0_hold) else $error("mode 0 output fell");
endmodule

bind pic_timer pic_timer_assertions u_chk (.clk(clk), .rstn(rstn), .bus(bus),
  .data_out(data_out), .data_oe(data_oe), .cnt_clk(cnt_clk), .gate(gate),
  .cnt_out(cnt_out));

// ---- tb/programmable_interval_counter_tb.sv ----
// Purpose: Self-checking bench for the interval counter.
// Assumes: Counter clocks are slow pulses made here, 8 clk per period.
// Notes:   Output expected from mode, count and ticks since load.
module programmable_interval_counter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pic_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [2:0]  cnt_clk = 3'h0;
  logic [2:0]  gate = 3'h7;
  pic_bus_t    bus;
  logic [7:0]  data_out;
  logic        data_oe;
  logic [2:0]  cnt_out;
  logic [31:0] seed = 32'hd613d63c;
  int          failures = 0;
  int          check_count = 0;

  // ********************************
  // Harness and helpers
  // ********************************

  // System clock, 100 MHz
  always #5 clk = ~clk;

  pic_host_model hm (.clk(clk), .bus(bus), .data_out(data_out), .data_oe(data_oe));
  pic_timer uut (.clk(clk), .rstn(rstn), .bus(bus), .data_out(data_out),
                 .data_oe(data_oe), .cnt_clk(cnt_clk), .gate(gate), .cnt_out(cnt_out));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Output level after i ticks past the load (or trigger)
  function automatic logic exp_out(input int m, input int n, input int i);
    case (m)
      0, 1:    return logic'(i >= n);
      2:       return logic'(i % n != n - 1);
      3:       return logic'(i % n < (n + 1) / 2);
      default: return logic'(i != n);
    endcase
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
    check_count++;
    if (seen !== want) begin
      failures++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, seen, want);
    end
  endtask

  // One counter clock pulse on counter c
  task automatic tick(input int c);
    @(negedge clk);
    cnt_clk[c] = 1'b1;
    repeat (3) @(negedge clk);
    cnt_clk[c] = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  // Two reads of counter 2, low byte first
  task automatic rd2(input logic [15:0] want);
    logic [7:0] d;
    logic       oe;
    hm.rd(2'h2, d, oe);
    check(d, want[7:0], "low byte");
    hm.rd(2'h2, d, oe);
    check(d, want[15:8], "high byte");
    check(oe, 1'b1, "read drive");
  endtask

  task automatic close_out();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out();
  end

  // Main sequence
  initial begin
    logic [7:0]  d;
    logic        oe;
    logic [15:0] v;
    logic [2:0]  code;
    int          c;
    int          n;
    int          k;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    // Every mode, binary then decimal, counters in turn
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 6; m++) begin
        c = m % 3;
        seed = lfsr(seed);
        n = (m == 3) ? 5 + p : 3 + int'(seed % 10);
        code = (m == 2 || m == 3) ? 3'(m + 4) : 3'(m);
        if (!(m == 1 || m == 5)) gate[c] = 1'b1;
        hm.wr(2'h3, {2'(c), PIC_ACC_BOTH, code, 1'(p)});
        if (m == 1 || m == 5) gate[c] = 1'b0;
        repeat (3) @(negedge clk);
        if (m % 2 == 0) check(cnt_out[c], m != 0, "mode set");
        v = p ? 16'((n / 10) * 16 + n % 10) : 16'(n);
        hm.wr(2'(c), v[7:0]);
        hm.wr(2'(c), v[15:8]);
        if (m == 2 || m == 3) begin
          gate[c] = 1'b0;
          @(negedge clk);
          gate[c] = 1'b1;
        end
        tick(c);
        if (m == 1 || m == 5) begin
          gate[c] = 1'b1;
          tick(c);
        end
        for (int i = 1; i <= 2 * n + 1; i++) begin
          // Mode 1 reload mid-pulse; mode 4 gate held low for one tick
          if (m == 1 && i == 2) begin
            hm.wr(2'(c), 8'h02);
            hm.wr(2'(c), 8'h00);
          end
          gate[c] = !(m == 4 && i == 1);
          tick(c);
          k = (m == 4 && i > 1) ? i - 1 : i;
          check(cnt_out[c], exp_out(m, n, k), "out");
        end
        $display("mode %0d count %0d pass %0d done", m, n, p);
      end
    end
    // Latch, illegal word, refused read, mode 0 rewrite
    hm.wr(2'h3, 8'hb0);
    hm.wr(2'h2, 8'h34);
    hm.wr(2'h2, 8'h12);
    repeat (5) tick(2);
    hm.wr(2'h3, 8'h80);
    repeat (2) tick(2);
    rd2(16'h1230);
    hm.wr(2'h3, 8'hf6);
    rd2(16'h122e);
    hm.rd(2'h3, d, oe);
    check(oe, 1'b0, "read of control port");
    hm.wr(2'h2, 8'h05);
    repeat (2) tick(2);
    hm.wr(2'h2, 8'h00);
    tick(2);
    for (int i = 1; i <= 6; i++) begin
      tick(2);
      check(cnt_out[2], i >= 5, "rewrite");
    end
    $display("latch and rewrite done");
    // Zero count wraps to the maximum in both arithmetics
    for (int p = 0; p < 2; p++) begin
      hm.wr(2'h3, {2'h2, PIC_ACC_BOTH, 3'h0, 1'(p)});
      hm.wr(2'h2, 8'h00);
      hm.wr(2'h2, 8'h00);
      repeat (3) tick(2);
      check(cnt_out[2], 1'b0, "zero count");
      rd2(p ? 16'h9998 : 16'hfffe);
    end
    // Single-byte access in each order
    hm.wr(2'h3, 8'h90);
    hm.wr(2'h2, 8'h07);
    repeat (2) tick(2);
    hm.rd(2'h2, d, oe);
    check(d, 8'h06, "low byte only");
    hm.wr(2'h3, 8'ha0);
    hm.wr(2'h2, 8'h12);
    repeat (2) tick(2);
    hm.rd(2'h2, d, oe);
    check(d, 8'h11, "high byte only");
    $display("zero count and single byte done");
    close_out();
  end
endmodule
